/* File: rtl/asuc_pkg.sv */
/*
 Constants, field layout and frame helpers shared by both ends of the serial link.
 Assumes both ends run from one 50 MHz ref_clk.
*/
package asuc_pkg;
	// ----------------------------------------
	// Mode register layout
	// ----------------------------------------
	localparam int MODE_TXE_BIT = 7;
	localparam int MODE_RXE_BIT = 6;
	localparam int MODE_PAR_LSB = 4;
	localparam int MODE_CL_BIT = 3;
	localparam int MODE_SL_BIT = 2;
	localparam int MODE_MASK_BIT = 1;
	localparam logic [7:0] MODE_RST = 8'h00;
	// ----------------------------------------
	// Error status layout
	// ----------------------------------------
	localparam int ERR_OVE_BIT = 0;
	localparam int ERR_FE_BIT = 1;
	localparam int ERR_PE_BIT = 2;
	localparam logic [2:0] ERR_RST = 3'h0;
	localparam logic [7:0] RXBUF_RST = 8'h00;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int BAUD_DIV_DEF = 16;
	localparam int REF_DIV_DEF = 4;
	localparam int SUP_REF_CLKS = 2;

	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_ZERO = 2'b01,
		PAR_ODD = 2'b10,
		PAR_EVEN = 2'b11
	} asuc_par_e;

	// Parity bit over 7 or 8 character bits
	function automatic logic par_bit(input logic [7:0] d, input logic eight, input logic [1:0] pm);
		logic x;
		x = eight ? ^d : ^d[6:0];
		case (pm)
			PAR_EVEN: par_bit = x;
			PAR_ODD: par_bit = ~x;
			default: par_bit = 1'b0;
		endcase
	endfunction

	// Whole frame, LSB first, idle-high fill
	function automatic logic [11:0] frame_build(input logic [7:0] d, input logic eight,
		input logic [1:0] pm);
		logic [11:0] f;
		logic [3:0] i;
		f = 12'hFFF;
		f[0] = 1'b0;
		f[8:1] = d;
		i = eight ? 4'h9 : 4'h8;
		if (!eight)
		begin
			f[8] = 1'b1;
		end
		if (pm != PAR_NONE)
		begin
			f[i] = par_bit(d, eight, pm);
		end
		frame_build = f;
	endfunction

	// Bits in a frame including start
	function automatic logic [3:0] frame_len(input logic eight, input logic [1:0] pm,
		input logic two);
		frame_len = 4'h9 + {3'h0, eight} + {3'h0, pm != PAR_NONE} + {3'h0, two};
	endfunction
endpackage

/* File: rtl/asuc_link_if.sv */
/*
 Serial link between the device end and the remote end.
 Assumes both ends share ref_clk; each line idles high.
*/
`timescale 1ns/1ps
interface asuc_link_if;
	logic dev_txd;
	logic host_txd;
	modport device (output dev_txd, input host_txd);
	modport host (output host_txd, input dev_txd);
endinterface

/* File: rtl/asuc_fifo.sv */
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock; in_ready is registered.
*/
`timescale 1ns/1ps
module asuc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rd_q];
	assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			wr_q <= push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
			rd_q <= pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
			cnt_q <= cnt_d;
			in_ready <= cnt_d != (AW + 1)'(DEPTH);
		end
	end
endmodule

/* File: rtl/asuc_host.sv */
/*
 Remote serial end: sends bytes from a 16-word FIFO, receives frames.
 Assumes the same frame format as the device; rxd arrives from outside.
*/
`timescale 1ns/1ps
module asuc_host
	import asuc_pkg::*;
#(
	parameter int BAUD_DIV = asuc_pkg::BAUD_DIV_DEF,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	asuc_link_if.host link,
	input wire logic cfg_eight,
	input wire logic [1:0] cfg_parity,
	input wire logic cfg_two_stop,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_perr,
	output logic rx_ferr
);
	import asuc_pkg::*;

	typedef enum logic [1:0] {H_IDLE = 2'b00, H_START = 2'b01, H_DATA = 2'b10} asuc_hrx_e;

	logic [7:0] f_data;
	logic f_valid;
	logic f_ready;
	logic tx_busy_q;
	logic [11:0] tx_fr_q;
	logic [3:0] tx_left_q;
	logic [15:0] tx_cnt_q;
	logic txd_q;
	logic [2:0] sync_q;
	logic lvl_q;
	asuc_hrx_e rx_st_q;
	logic [15:0] rx_cnt_q;
	logic [3:0] rx_left_q;
	logic [9:0] rx_sh_q;
	logic [9:0] sh_nx;
	logic [9:0] bits;
	logic [3:0] n_after;
	logic [7:0] ch;

	asuc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	assign f_ready = !tx_busy_q;
	assign link.host_txd = txd_q;

	// ----------------------------------------
	// Transmit
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_busy_q <= 1'b0;
			tx_fr_q <= 12'hFFF;
			tx_left_q <= 4'h0;
			tx_cnt_q <= 16'h0000;
			txd_q <= 1'b1;
		end
		else if (!tx_busy_q)
		begin
			if (f_valid)
			begin
				tx_busy_q <= 1'b1;
				tx_fr_q <= frame_build(f_data, cfg_eight, cfg_parity);
				tx_left_q <= frame_len(cfg_eight, cfg_parity, cfg_two_stop);
				tx_cnt_q <= 16'(BAUD_DIV - 1);
				txd_q <= 1'b0;
			end
		end
		else if (tx_cnt_q != 16'h0000)
		begin
			tx_cnt_q <= tx_cnt_q - 16'h0001;
		end
		else if (tx_left_q == 4'h1)
		begin
			tx_busy_q <= 1'b0;
			txd_q <= 1'b1;
		end
		else
		begin
			tx_fr_q <= {1'b1, tx_fr_q[11:1]};
			txd_q <= tx_fr_q[1];
			tx_left_q <= tx_left_q - 4'h1;
			tx_cnt_q <= 16'(BAUD_DIV - 1);
		end
	end

	// ----------------------------------------
	// Receive
	// ----------------------------------------
	always_comb
	begin
		n_after = frame_len(cfg_eight, cfg_parity, 1'b0) - 4'h1;
		sh_nx = {lvl_q, rx_sh_q[9:1]};
		bits = sh_nx >> (4'hA - n_after);
		ch = cfg_eight ? bits[7:0] : {1'b0, bits[6:0]};
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync_q <= 3'h7;
			lvl_q <= 1'b1;
		end
		else
		begin
			sync_q <= {sync_q[1:0], link.dev_txd};
			if (sync_q[1] == sync_q[2])
			begin
				lvl_q <= sync_q[2];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_st_q <= H_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_left_q <= 4'h0;
			rx_sh_q <= 10'h000;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			rx_perr <= 1'b0;
			rx_ferr <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			rx_cnt_q <= (rx_cnt_q != 16'h0000) ? rx_cnt_q - 16'h0001 : rx_cnt_q;
			unique case (rx_st_q)
				H_IDLE:
				begin
					if (!lvl_q)
					begin
						rx_st_q <= H_START;
						rx_cnt_q <= 16'(BAUD_DIV / 2 - 1);
					end
				end
				H_START:
				begin
					if (rx_cnt_q == 16'h0000)
					begin
						rx_st_q <= lvl_q ? H_IDLE : H_DATA;
						rx_cnt_q <= 16'(BAUD_DIV - 1);
						rx_left_q <= n_after;
					end
				end
				H_DATA:
				begin
					if (rx_cnt_q == 16'h0000)
					begin
						rx_sh_q <= sh_nx;
						rx_cnt_q <= 16'(BAUD_DIV - 1);
						rx_left_q <= rx_left_q - 4'h1;
						if (rx_left_q == 4'h1)
						begin
							rx_st_q <= H_IDLE;
							rx_data <= ch;
							rx_valid <= 1'b1;
							rx_perr <= cfg_parity[1] &&
								(bits[cfg_eight ? 8 : 7] != par_bit(ch, cfg_eight, cfg_parity));
							rx_ferr <= !bits[n_after - 4'h1];
						end
					end
				end
			endcase
		end
	end
endmodule

/* File: rtl/asuc_device.sv */
/*
 Device end of the asynchronous serial core: mode register, transmitter,
 receiver, receive buffer, error status and interrupt pulses.
 Assumes register accesses arrive as one-cycle strobes on ref_clk.
*/
`timescale 1ns/1ps
module asuc_device
	import asuc_pkg::*;
#(
	parameter int BAUD_DIV = asuc_pkg::BAUD_DIV_DEF,
	parameter int REF_DIV = asuc_pkg::REF_DIV_DEF
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	asuc_link_if.device link,
	input wire logic mode_wr,
	input wire logic [7:0] mode_wdata,
	input wire logic tx_wr,
	input wire logic [7:0] tx_wdata,
	input wire logic rx_rd,
	input wire logic tx_flag_clr,
	output logic [7:0] serial_mode_reg,
	output logic [7:0] rx_buffer,
	output logic [2:0] rx_error_status,
	output logic tx_done_irq,
	output logic rx_done_irq,
	output logic rx_error_irq,
	output logic tx_done_req_flag,
	output logic tx_busy
);
	import asuc_pkg::*;

	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10} asuc_rx_e;

	localparam logic [15:0] SUP_CYC = 16'(SUP_REF_CLKS * REF_DIV);

	logic tx_enable;
	logic rx_enable;
	logic eight;
	logic two_stop;
	logic err_rx_irq_mask;
	logic [1:0] pmode;
	logic [11:0] tx_shift_reg;
	logic [3:0] tx_left_q;
	logic [15:0] tx_cnt_q;
	logic txd_q;
	logic tx_end;
	logic [2:0] sync_q;
	logic lvl_q;
	asuc_rx_e rx_st_q;
	logic [15:0] rx_cnt_q;
	logic [3:0] rx_left_q;
	logic [9:0] rx_sh_q;
	logic [9:0] sh_nx;
	logic [9:0] bits;
	logic [3:0] n_after;
	logic [7:0] ch;
	logic pe;
	logic fe;
	logic overrun_flag;
	logic any_err;
	logic rx_end;
	logic rx_full_q;
	logic [15:0] sup_cnt_q;

	assign tx_enable = serial_mode_reg[MODE_TXE_BIT];
	assign rx_enable = serial_mode_reg[MODE_RXE_BIT];
	assign pmode = serial_mode_reg[MODE_PAR_LSB +: 2];
	assign eight = serial_mode_reg[MODE_CL_BIT];
	assign two_stop = serial_mode_reg[MODE_SL_BIT];
	assign err_rx_irq_mask = serial_mode_reg[MODE_MASK_BIT];
	assign link.dev_txd = txd_q;

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			serial_mode_reg <= MODE_RST;
		end
		else if (mode_wr)
		begin
			serial_mode_reg <= mode_wdata;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	assign tx_end = tx_busy && tx_enable && tx_cnt_q == 16'h0000 && tx_left_q == 4'h1;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_busy <= 1'b0;
			tx_shift_reg <= 12'hFFF;
			tx_left_q <= 4'h0;
			tx_cnt_q <= 16'h0000;
			txd_q <= 1'b1;
		end
		else if (!tx_enable)
		begin
			tx_busy <= 1'b0;
			txd_q <= 1'b1;
		end
		else if (!tx_busy)
		begin
			if (tx_wr)
			begin
				tx_busy <= 1'b1;
				tx_shift_reg <= frame_build(tx_wdata, eight, pmode);
				tx_left_q <= frame_len(eight, pmode, two_stop);
				tx_cnt_q <= 16'(BAUD_DIV - 1);
				txd_q <= 1'b0;
			end
		end
		else if (tx_cnt_q != 16'h0000)
		begin
			tx_cnt_q <= tx_cnt_q - 16'h0001;
		end
		else if (tx_left_q == 4'h1)
		begin
			tx_busy <= 1'b0;
			txd_q <= 1'b1;
		end
		else
		begin
			tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
			txd_q <= tx_shift_reg[1];
			tx_left_q <= tx_left_q - 4'h1;
			tx_cnt_q <= 16'(BAUD_DIV - 1);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_done_irq <= 1'b0;
			tx_done_req_flag <= 1'b0;
		end
		else
		begin
			tx_done_irq <= tx_end;
			tx_done_req_flag <= tx_end || (tx_done_req_flag && !tx_flag_clr);
		end
	end

	// ----------------------------------------
	// Receive input filter
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync_q <= 3'h7;
			lvl_q <= 1'b1;
		end
		else
		begin
			sync_q <= {sync_q[1:0], link.host_txd};
			if (sync_q[1] == sync_q[2])
			begin
				lvl_q <= sync_q[2];
			end
		end
	end

	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	always_comb
	begin
		n_after = frame_len(eight, pmode, 1'b0) - 4'h1;
		sh_nx = {lvl_q, rx_sh_q[9:1]};
		bits = sh_nx >> (4'hA - n_after);
		ch = eight ? bits[7:0] : {1'b0, bits[6:0]};
		pe = pmode[1] && (bits[eight ? 8 : 7] != par_bit(ch, eight, pmode));
		fe = !bits[n_after - 4'h1];
		overrun_flag = rx_full_q;
		any_err = pe || fe || overrun_flag;
	end

	assign rx_end = rx_enable && rx_st_q == RX_DATA && rx_cnt_q == 16'h0000 &&
		rx_left_q == 4'h1;

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_left_q <= 4'h0;
			rx_sh_q <= 10'h000;
		end
		else if (!rx_enable)
		begin
			rx_st_q <= RX_IDLE;
		end
		else
		begin
			rx_cnt_q <= (rx_cnt_q != 16'h0000) ? rx_cnt_q - 16'h0001 : rx_cnt_q;
			unique case (rx_st_q)
				RX_IDLE:
				begin
					if (!lvl_q)
					begin
						rx_st_q <= RX_START;
						rx_cnt_q <= 16'(BAUD_DIV / 2 - 1);
					end
				end
				RX_START:
				begin
					if (rx_cnt_q == 16'h0000)
					begin
						rx_st_q <= lvl_q ? RX_IDLE : RX_DATA;
						rx_cnt_q <= 16'(BAUD_DIV - 1);
						rx_left_q <= n_after;
					end
				end
				RX_DATA:
				begin
					if (rx_cnt_q == 16'h0000)
					begin
						rx_sh_q <= sh_nx;
						rx_cnt_q <= 16'(BAUD_DIV - 1);
						rx_left_q <= rx_left_q - 4'h1;
						if (rx_left_q == 4'h1)
						begin
							rx_st_q <= RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Receive buffer and error status
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_buffer <= RXBUF_RST;
			rx_error_status <= ERR_RST;
			rx_full_q <= 1'b0;
		end
		else if (rx_end)
		begin
			rx_buffer <= ch;
			rx_error_status[ERR_PE_BIT] <= pe;
			rx_error_status[ERR_FE_BIT] <= fe;
			rx_error_status[ERR_OVE_BIT] <= overrun_flag;
			rx_full_q <= 1'b1;
		end
		else if (rx_rd)
		begin
			rx_error_status <= ERR_RST;
			rx_full_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Receive interrupts
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
			sup_cnt_q <= 16'h0000;
		end
		else if (rx_end)
		begin
			rx_error_irq <= any_err;
			rx_done_irq <= !any_err || !err_rx_irq_mask;
			sup_cnt_q <= (any_err && err_rx_irq_mask) ? SUP_CYC : 16'h0000;
		end
		else
		begin
			rx_error_irq <= 1'b0;
			rx_done_irq <= rx_rd && sup_cnt_q != 16'h0000;
			sup_cnt_q <= (rx_rd || sup_cnt_q == 16'h0000) ? 16'h0000 : sup_cnt_q - 16'h0001;
		end
	end
endmodule

/* File: testbench/asuc_assertions.sv */
/*
 Checker for the device end of the serial link, fed with plain signals.
 Assumes BAUD_DIV is 4, matching the start-bit repetition below.
*/
`timescale 1ns/1ps
module asuc_assertions
	import asuc_pkg::*;
#(
	parameter int BAUD_DIV = 4
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic dev_txd,
	input wire logic tx_wr,
	input wire logic [7:0] serial_mode_reg,
	input wire logic tx_busy,
	input wire logic tx_done_irq,
	input wire logic [2:0] rx_error_status,
	input wire logic rx_error_irq,
	input wire logic rx_done_irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ----
	// Busy cycle counter
	// ----
	logic [7:0] busy_cnt_q;
	int frame_cyc;
	assign frame_cyc = (9 + int'(serial_mode_reg[3]) + int'(serial_mode_reg[5:4] != 2'b00)
		+ int'(serial_mode_reg[2])) * BAUD_DIV;
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy_cnt_q <= 8'h00;
		end
		else
		begin
			busy_cnt_q <= tx_busy ? busy_cnt_q + 8'h01 : 8'h00;
		end
	end
	// ----
	// Properties
	// ----
	idle_high_a: assert property (!tx_busy |-> dev_txd)
		else $error("line not high while idle");
	start_bit_a: assert property ($rose(tx_busy) |-> !dev_txd [*4])
		else $error("start bit wrong");
	tx_start_a: assert property (tx_wr && serial_mode_reg[7] && !tx_busy |=> tx_busy)
		else $error("write did not start frame");
	tx_ignore_a: assert property (tx_wr && !serial_mode_reg[7] && !tx_busy |=> !tx_busy)
		else $error("frame started while disabled");
	frame_len_a: assert property (tx_done_irq |-> int'(busy_cnt_q) == frame_cyc)
		else $error("frame length wrong");
	tx_done_a: assert property (tx_done_irq |-> $past(tx_busy) && dev_txd)
		else $error("done pulse without frame");
	tx_abort_a: assert property (tx_busy && !serial_mode_reg[7] |=> !tx_busy && !tx_done_irq)
		else $error("abort not immediate");
	err_irq_a: assert property (rx_error_irq |-> rx_error_status != 3'h0)
		else $error("error pulse without flag");
	err_set_a: assert property ($changed(rx_error_status) && rx_error_status != 3'h0
		|-> rx_error_irq)
		else $error("flag set without pulse");
	err_done_a: assert property (rx_error_irq && !serial_mode_reg[1] |-> rx_done_irq)
		else $error("unmasked error lost done pulse");
endmodule

/* File: testbench/asuc_tb.sv */
/*
 Self-checking bench: device and host joined by the link interface.
 Assumes BAUD_DIV 4 to keep frames short and REF_DIV 1 to keep the done-pulse hold-off short.
*/
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module asuc_tb;
	import asuc_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic mode_wr = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0, tx_flag_clr = 1'b0;
	logic [7:0] mode_wdata = 8'h00, tx_wdata = 8'h00, h_data = 8'h00;
	logic h_eight = 1'b0, h_two = 1'b0, h_valid = 1'b0;
	logic [1:0] h_par = 2'b00;
	logic [7:0] serial_mode_reg, rx_buffer, h_rx;
	logic [2:0] rx_error_status;
	logic tx_done_irq, rx_done_irq, rx_error_irq, tx_done_req_flag, tx_busy;
	logic h_ready, h_rxv, h_perr, h_ferr;
	int checks = 0, failures = 0, n_ev = 0, n_done = 0, n_err = 0, n_tdone = 0;
	asuc_link_if link();
	asuc_device #(.BAUD_DIV(4), .REF_DIV(1)) asuc_device_inst (.ref_clk(ref_clk),
		.reset_n(reset_n), .link(link), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
		.tx_wr(tx_wr), .tx_wdata(tx_wdata), .rx_rd(rx_rd), .tx_flag_clr(tx_flag_clr),
		.serial_mode_reg(serial_mode_reg), .rx_buffer(rx_buffer),
		.rx_error_status(rx_error_status), .tx_done_irq(tx_done_irq),
		.rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq),
		.tx_done_req_flag(tx_done_req_flag), .tx_busy(tx_busy));
	asuc_host #(.BAUD_DIV(4), .FIFO_DEPTH(16)) asuc_host_inst (.ref_clk(ref_clk),
		.reset_n(reset_n), .link(link), .cfg_eight(h_eight), .cfg_parity(h_par),
		.cfg_two_stop(h_two), .tx_data(h_data), .tx_valid(h_valid), .tx_ready(h_ready),
		.rx_data(h_rx), .rx_valid(h_rxv), .rx_perr(h_perr), .rx_ferr(h_ferr));
	asuc_assertions #(.BAUD_DIV(4)) asuc_assertions_inst (.ref_clk(ref_clk),
		.reset_n(reset_n), .dev_txd(link.dev_txd), .tx_wr(tx_wr),
		.serial_mode_reg(serial_mode_reg), .tx_busy(tx_busy), .tx_done_irq(tx_done_irq),
		.rx_error_status(rx_error_status), .rx_error_irq(rx_error_irq),
		.rx_done_irq(rx_done_irq));
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		n_ev <= n_ev + int'(rx_done_irq || rx_error_irq || h_rxv);
		n_done <= n_done + int'(rx_done_irq);
		n_err <= n_err + int'(rx_error_irq);
		n_tdone <= n_tdone + int'(tx_done_irq);
	end
	// ----
	// Helpers
	// ----
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic set_mode(input logic [7:0] m);
		mode_wdata = m;
		mode_wr = 1'b1;
		cyc(1);
		mode_wr = 1'b0;
		h_eight = m[3];
		h_par = m[5:4];
		h_two = m[2];
	endtask
	task automatic rd();
		rx_rd = 1'b1;
		cyc(1);
		rx_rd = 1'b0;
	endtask
	task automatic tx_pulse(input logic [7:0] d);
		tx_wdata = d;
		tx_wr = 1'b1;
		cyc(1);
		tx_wr = 1'b0;
	endtask
	task automatic wait_ev(input int base);
		int t;
		for (t = 0; t < 300 && n_ev == base; t++) cyc(1);
		if (n_ev == base)
		begin
			failures++;
			$display("[ERR] wait exp event got none");
			complete_run();
		end
	endtask
	function automatic logic [11:0] exp_frame(input logic [7:0] d, input logic [7:0] m);
		logic [11:0] f;
		logic p;
		f = 12'hFFF;
		p = m[3] ? ^d : ^d[6:0];
		f[0] = 1'b0;
		f[7:1] = d[6:0];
		if (m[3]) f[8] = d[7];
		if (m[5:4] != 2'b00) f[m[3] ? 9 : 8] = m[5] & (m[4] ? p : ~p);
		return f;
	endfunction
	// ----
	// Scenarios
	// ----
	task automatic dev_send(input logic [7:0] d);
		logic [11:0] s;
		int k, n, b;
		s = 12'hFFF;
		b = n_ev;
		n = 9 + int'(serial_mode_reg[3]) + int'(serial_mode_reg[5:4] != 2'b00)
			+ int'(serial_mode_reg[2]);
		tx_pulse(d);
		`CHK("tx_busy", 1'b1, tx_busy)
		for (k = 0; k < n; k++)
		begin
			cyc(1);
			s[k] = link.dev_txd;
			cyc(3);
		end
		`CHK("tx_done_irq", 1'b1, tx_done_irq)
		`CHK("frame", exp_frame(d, serial_mode_reg), s)
		`CHK("tx_done_req_flag", 1'b1, tx_done_req_flag)
		tx_flag_clr = 1'b1;
		cyc(1);
		tx_flag_clr = 1'b0;
		wait_ev(b);
		`CHK("host rx", serial_mode_reg[3] ? d : {1'b0, d[6:0]}, h_rx)
		`CHK("host perr", 1'b0, h_perr)
		`CHK("host ferr", 1'b0, h_ferr)
	endtask
	task automatic host_send(input logic [7:0] d, input logic [2:0] st, input logic early);
		int b, dn, er;
		b = n_ev;
		dn = n_done;
		er = n_err;
		h_data = d;
		h_valid = 1'b1;
		cyc(1);
		h_valid = 1'b0;
		wait_ev(b);
		`CHK("rx_buffer", serial_mode_reg[3] ? d : {1'b0, d[6:0]}, rx_buffer)
		`CHK("rx_error_status", st, rx_error_status)
		`CHK("rx_error_irq", int'(st != 3'h0), n_err - er)
		if (early) rd();
		cyc(4);
		`CHK("rx_done_irq", int'(st == 3'h0 || !serial_mode_reg[1] || early), n_done - dn)
	endtask
	// ----
	// Main sequence
	// ----
	initial
	begin
		int i, b, acc;
		logic full;
		logic [7:0] keep;
		logic [1:0] dp [3] = '{2'b10, 2'b11, 2'b01};
		logic [1:0] hp [3] = '{2'b11, 2'b10, 2'b11};
		logic [2:0] st [3] = '{3'h4, 3'h4, 3'h0};
		cyc(2);
		reset_n = 1'b1;
		cyc(2);
		`CHK("dev_txd", 1'b1, link.dev_txd)
		`CHK("serial_mode_reg", MODE_RST, serial_mode_reg)
		`CHK("tx_done count", 0, n_tdone)
		for (i = 0; i < 8; i++)
		begin
			set_mode({2'b11, i[1:0], i[2], i[0] ^ i[2], 2'b00});
			dev_send(8'hB5 ^ 8'(i));
			host_send(8'hE9 - 8'(i), 3'h0, 1'b0);
			rd();
		end
		for (i = 0; i < 3; i++)
		begin
			set_mode({2'b01, dp[i], 4'h8});
			h_par = hp[i];
			host_send(8'h5B, st[i], 1'b0);
			rd();
		end
		set_mode(8'h78);
		h_par = 2'b10;
		host_send(8'h5B, 3'h4, 1'b0);
		h_par = 2'b11;
		host_send(8'h33, 3'h1, 1'b0);
		rd();
		`CHK("status after read", 3'h0, rx_error_status)
		set_mode(8'h40);
		h_eight = 1'b1;
		host_send(8'h00, 3'h2, 1'b0);
		rd();
		set_mode(8'h7A);
		h_par = 2'b10;
		host_send(8'h5B, 3'h4, 1'b0);
		b = n_done;
		rd();
		cyc(3);
		`CHK("late read done", 0, n_done - b)
		host_send(8'h5B, 3'h4, 1'b1);
		set_mode(8'h88);
		tx_pulse(8'h0F);
		cyc(10);
		b = n_tdone;
		set_mode(8'h08);
		cyc(2);
		`CHK("abort busy", 1'b0, tx_busy)
		`CHK("abort txd", 1'b1, link.dev_txd)
		tx_pulse(8'h55);
		cyc(60);
		`CHK("abort no done", 0, n_tdone - b)
		set_mode(8'h48);
		keep = rx_buffer;
		b = n_done + n_err;
		h_data = 8'hC3;
		h_valid = 1'b1;
		cyc(1);
		h_valid = 1'b0;
		cyc(20);
		set_mode(8'h08);
		cyc(60);
		`CHK("rx stop buffer", keep, rx_buffer)
		`CHK("rx stop irqs", b, n_done + n_err)
		set_mode(8'h48);
		acc = 0;
		full = 1'b0;
		b = n_ev;
		h_valid = 1'b1;
		for (i = 0; i < 24; i++)
		begin
			h_data = 8'(acc);
			if (h_ready) acc++;
			else full = 1'b1;
			cyc(1);
		end
		h_valid = 1'b0;
		`CHK("fifo refused", 1'b1, full)
		for (i = 0; i < acc; i++)
		begin
			wait_ev(b);
			`CHK("fifo data", 8'(i), rx_buffer)
			b = n_ev;
			rd();
		end
		`CHK("fifo drained", 1'b1, h_ready)
		complete_run();
	end
endmodule
